// *** verilog/event_output_conditioner.sv ***
// event output conditioner: polarity, standby, ready handling, alarm combining, bus registers
`timescale 1ns/1ps
`default_nettype none
module event_output_conditioner #(
    parameter int SP_W = 16
) (
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // event path, all from logic on this clock
    input wire logic RAW_DECISION_IN,
    input wire logic READY_MODE_IN,
    input wire logic [SP_W-1:0] SETPOINT_VALUE_IN,
    input wire logic ALARM_ACTIVE_IN,
    output logic EVENT_OUT,
    output logic STANDBY_ARMED_OUT
);
    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (SP_W < 1 || SP_W > 32) begin : g_bad_sp_w
        $error("SP_W must lie between 1 and 32");
    end

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } bus_e;

    typedef struct packed {
        bus_e bus;
        logic [event_cond_pkg::ADDR_W-1:0] addr;
        logic [event_cond_pkg::CFG_W-1:0] cfg2;
        logic [event_cond_pkg::CFG_W-1:0] cfg3;
        logic [event_cond_pkg::OPTYPE_W-1:0] optype;
        logic [31:0] rdata;
        logic event_on;
        logic ready_prev;
    } top_s;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // picks one decimal digit out of a configuration word
    function automatic logic [3:0] digit(input logic [15:0] word, input logic [1:0] idx);
        logic [3:0] d;
        case (idx)
            2'h0: d = word[3:0];
            2'h1: d = word[7:4];
            2'h2: d = word[11:8];
            default: d = word[15:12];
        endcase
        return d;
    endfunction : digit

    top_s cur;
    top_s next_cur;
    logic addr_phase;
    logic [3:0] pol_digit;
    logic [3:0] supp_digit;
    logic [3:0] ready_digit;
    logic [3:0] alarm_digit;
    logic supp_active;
    logic sp_rearm_en;
    logic armed;
    logic polar;
    logic held;
    logic combined;
    logic enabled;

    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    // digits above the listed codes behave like code 0
    assign pol_digit = digit(cur.cfg2, event_cond_pkg::DIG_FIRST);
    assign supp_digit = digit(cur.cfg2, event_cond_pkg::DIG_SECOND);
    assign ready_digit = digit(cur.cfg2, event_cond_pkg::DIG_THIRD);
    assign alarm_digit = digit(cur.cfg3, event_cond_pkg::DIG_FIRST);
    assign supp_active = (supp_digit == event_cond_pkg::SUPP_STANDBY) ||
                         (supp_digit == event_cond_pkg::SUPP_STANDBY_SP);
    assign sp_rearm_en = (supp_digit == event_cond_pkg::SUPP_STANDBY_SP);
    assign enabled = (cur.optype != event_cond_pkg::OPTYPE_NONE);

    // ----------------------------------------------------------------
    // standby tracking
    // ----------------------------------------------------------------
    // the tracker always runs so a later switch to standby sees a sane state
    standby_tracker #(
        .SP_W(SP_W)
    ) i_standby_tracker (
        .clk_in(SYS_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .raw_on_in(RAW_DECISION_IN),
        .ready_in(READY_MODE_IN),
        .sp_rearm_en_in(sp_rearm_en),
        .setpoint_value_in(SETPOINT_VALUE_IN),
        .armed_out(armed)
    );

    // ----------------------------------------------------------------
    // event path
    // ----------------------------------------------------------------
    // polarity first, then standby hold and ready gating
    always_comb begin
        polar = RAW_DECISION_IN ^ (pol_digit == event_cond_pkg::POL_REVERSE);
        held = polar;
        // the arm from leaving ready lands one edge late, so that edge is held here too
        if (supp_active && (armed || (cur.ready_prev && !READY_MODE_IN))) begin
            held = 1'b0;
        end
        if (READY_MODE_IN && (supp_active || ready_digit == event_cond_pkg::READY_FORCE_OFF)) begin
            held = 1'b0;
        end
    end

    alarm_combiner i_alarm_combiner (
        .mode_in(alarm_digit),
        .event_in(held),
        .alarm_in(ALARM_ACTIVE_IN),
        .combined_out(combined)
    );

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // only whole-word transfers are taken; other sizes complete but do nothing
    assign addr_phase = HSEL_IN && HREADY_IN && HTRANS_IN[1] && (HSIZE_IN == event_cond_pkg::HSIZE_WORD);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // reads take one wait state so the read word comes from a flip-flop
    // and already reflects a write that finished one cycle before
    always_comb begin
        next_cur = cur;
        // output stage: disabled instance stays off
        next_cur.event_on = enabled ? combined : 1'b0;
        next_cur.ready_prev = READY_MODE_IN;
        case (cur.bus)
            BUS_WRITE: begin
                case (cur.addr)
                    event_cond_pkg::OFS_CFG2: next_cur.cfg2 = HWDATA_IN[15:0];
                    event_cond_pkg::OFS_CFG3: next_cur.cfg3 = HWDATA_IN[15:0];
                    event_cond_pkg::OFS_OPTYPE: next_cur.optype = HWDATA_IN[7:0];
                    default: next_cur.optype = cur.optype;
                endcase
                next_cur.bus = BUS_IDLE;
            end
            BUS_READ: begin
                next_cur.rdata = '0;
                case (cur.addr)
                    event_cond_pkg::OFS_CFG2: next_cur.rdata[15:0] = cur.cfg2;
                    event_cond_pkg::OFS_CFG3: next_cur.rdata[15:0] = cur.cfg3;
                    event_cond_pkg::OFS_OPTYPE: next_cur.rdata[7:0] = cur.optype;
                    event_cond_pkg::OFS_STATUS: begin
                        next_cur.rdata[event_cond_pkg::ST_EVENT] = cur.event_on;
                        next_cur.rdata[event_cond_pkg::ST_ARMED] = armed;
                        next_cur.rdata[event_cond_pkg::ST_RAW] = RAW_DECISION_IN;
                        next_cur.rdata[event_cond_pkg::ST_READY] = READY_MODE_IN;
                    end
                    default: next_cur.rdata = '0;
                endcase
                next_cur.bus = BUS_IDLE;
            end
            BUS_IDLE: next_cur.bus = BUS_IDLE;
            default: next_cur.bus = BUS_IDLE;
        endcase
        // a new address phase is accepted when hready is high, except during the read wait state
        if (addr_phase && cur.bus != BUS_READ) begin
            next_cur.addr = {HADDR_IN[event_cond_pkg::ADDR_W-1:2], 2'b00};
            next_cur.bus = HWRITE_IN ? BUS_WRITE : BUS_READ;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cur <= '{bus: BUS_IDLE,
                     addr: '0,
                     cfg2: event_cond_pkg::CFG2_RST,
                     cfg3: event_cond_pkg::CFG3_RST,
                     optype: event_cond_pkg::OPTYPE_RST,
                     rdata: '0,
                     event_on: 1'b0,
                     ready_prev: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // hready drops only during the read wait state
    assign HREADYOUT_OUT = (cur.bus != BUS_READ);
    assign HRESP_OUT = event_cond_pkg::HRESP_OKAY;
    assign HRDATA_OUT = cur.rdata;
    assign EVENT_OUT = cur.event_on;
    assign STANDBY_ARMED_OUT = armed;
endmodule : event_output_conditioner
`default_nettype wire

// *** verilog/event_cond_pkg.sv ***
// constants shared by the event output conditioner and its helpers
`default_nettype none
package event_cond_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CFG2 = 8'h00;
    localparam logic [7:0] OFS_CFG3 = 8'h04;
    localparam logic [7:0] OFS_OPTYPE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG2_RST = 16'h0000;
    localparam logic [15:0] CFG3_RST = 16'h0000;
    localparam logic [7:0] OPTYPE_RST = 8'h00;
    // ----------------------------------------------------------------
    // digit fields: four decimal digits, first digit rightmost
    // ----------------------------------------------------------------
    localparam int DIGIT_W = 4;
    localparam int CFG_W = 16;
    localparam int OPTYPE_W = 8;
    localparam logic [1:0] DIG_FIRST = 2'h0;
    localparam logic [1:0] DIG_SECOND = 2'h1;
    localparam logic [1:0] DIG_THIRD = 2'h2;
    // ----------------------------------------------------------------
    // digit codes
    // ----------------------------------------------------------------
    localparam logic [3:0] POL_REVERSE = 4'h1;
    localparam logic [3:0] SUPP_STANDBY = 4'h1;
    localparam logic [3:0] SUPP_STANDBY_SP = 4'h2;
    localparam logic [3:0] READY_FORCE_OFF = 4'h1;
    localparam logic [3:0] ALM_NONE = 4'h0;
    localparam logic [3:0] ALM_DIR_OR = 4'h1;
    localparam logic [3:0] ALM_DIR_AND = 4'h2;
    localparam logic [3:0] ALM_REV_OR = 4'h3;
    localparam logic [3:0] ALM_REV_AND = 4'h4;
    localparam logic [7:0] OPTYPE_NONE = 8'h00;
    // ----------------------------------------------------------------
    // status word bit positions
    // ----------------------------------------------------------------
    localparam int ST_EVENT = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_RAW = 2;
    localparam int ST_READY = 3;
    // ----------------------------------------------------------------
    // bus codes
    // ----------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : event_cond_pkg
`default_nettype wire

// *** verilog/alarm_combiner.sv ***
// combines the conditioned event with the instrument alarm status
`timescale 1ns/1ps
`default_nettype none
module alarm_combiner (
    input wire logic [3:0] mode_in,
    input wire logic event_in,
    input wire logic alarm_in,
    output logic combined_out
);
    // ----------------------------------------------------------------
    // combining table
    // ----------------------------------------------------------------
    // unknown codes fall back to pass-through, the safest reading
    always_comb begin
        case (mode_in)
            event_cond_pkg::ALM_NONE: combined_out = event_in;
            event_cond_pkg::ALM_DIR_OR: combined_out = event_in | alarm_in;
            event_cond_pkg::ALM_DIR_AND: combined_out = event_in & alarm_in;
            event_cond_pkg::ALM_REV_OR: combined_out = event_in | ~alarm_in;
            event_cond_pkg::ALM_REV_AND: combined_out = event_in & ~alarm_in;
            default: combined_out = event_in;
        endcase
    end
endmodule : alarm_combiner
`default_nettype wire

// *** verilog/standby_tracker.sv ***
// arms and releases the standby hold of one event
`timescale 1ns/1ps
`default_nettype none
module standby_tracker #(
    parameter int SP_W = 16
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic raw_on_in,
    input wire logic ready_in,
    input wire logic sp_rearm_en_in,
    input wire logic [SP_W-1:0] setpoint_value_in,
    output logic armed_out
);
    typedef struct packed {
        logic armed;
        logic ready_prev;
        logic sp_valid;
        logic [SP_W-1:0] sp_prev;
    } trk_s;

    trk_s cur;
    trk_s next_cur;
    logic run_entry;
    logic sp_changed;

    // ----------------------------------------------------------------
    // arming and release
    // ----------------------------------------------------------------
    // a new arm beats a release in the same cycle, so no arm is lost
    always_comb begin
        next_cur = cur;
        run_entry = cur.ready_prev & ~ready_in;
        // a rewrite of the same value, or a group swap to an equal value, compares equal
        sp_changed = cur.sp_valid && (setpoint_value_in != cur.sp_prev);
        next_cur.ready_prev = ready_in;
        next_cur.sp_prev = setpoint_value_in;
        next_cur.sp_valid = 1'b1;
        if (cur.armed && !raw_on_in) begin
            next_cur.armed = 1'b0;
        end
        if (run_entry || (sp_rearm_en_in && sp_changed)) begin
            next_cur.armed = 1'b1;
        end
    end

    // power-up arms the hold
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cur <= '{armed: 1'b1, ready_prev: 1'b0, sp_valid: 1'b0, sp_prev: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign armed_out = cur.armed;
endmodule : standby_tracker
`default_nettype wire

// *** test/event_output_conditioner_assertions.sv ***
// concurrent checks on the ports of the event output conditioner
`timescale 1ns/1ps
`default_nettype none
module event_output_conditioner_assertions #(
    parameter int SP_W = 16
) (
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic RAW_DECISION_IN,
    input wire logic READY_MODE_IN,
    input wire logic [SP_W-1:0] SETPOINT_VALUE_IN,
    input wire logic ALARM_ACTIVE_IN,
    input wire logic EVENT_OUT,
    input wire logic STANDBY_ARMED_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    // ----------------------------------------------------------------
    // transfer decode and step sequences
    // ----------------------------------------------------------------
    logic take;
    assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1] && (HSIZE_IN == event_cond_pkg::HSIZE_WORD);
    sequence s_read_walk;
        !HREADYOUT_OUT ##1 HREADYOUT_OUT;
    endsequence
    // past reset guards against history captured while in reset
    sequence s_ready_left;
        $fell(READY_MODE_IN) && $past(ARST_N_IN);
    endsequence
    a_bus_okay: assert property (HRESP_OUT == event_cond_pkg::HRESP_OKAY) else $error("response not okay");
    a_read_wait: assert property (take && !HWRITE_IN |=> s_read_walk) else $error("read wait wrong");
    a_write_nowait: assert property (take && HWRITE_IN |=> HREADYOUT_OUT) else $error("write stalled");
    a_rdata_held: assert property ($changed(HRDATA_OUT) |-> $past(HREADYOUT_OUT) == 1'b0)
        else $error("read data moved outside a read");
    a_reset_armed: assert property ($rose(ARST_N_IN) |-> STANDBY_ARMED_OUT) else $error("not armed at power-up");
    a_ready_rearm: assert property (s_ready_left |=> STANDBY_ARMED_OUT) else $error("no arm on leaving ready");
    a_release_raw: assert property ($fell(STANDBY_ARMED_OUT) |-> $past(RAW_DECISION_IN) == 1'b0)
        else $error("standby released without off");
    a_armed_hold: assert property (STANDBY_ARMED_OUT && RAW_DECISION_IN |=> STANDBY_ARMED_OUT)
        else $error("standby dropped while on");
    a_sp_quiet: assert property (!STANDBY_ARMED_OUT && $stable(SETPOINT_VALUE_IN) && !$fell(READY_MODE_IN)
        && $past(ARST_N_IN) |=> !STANDBY_ARMED_OUT) else $error("armed without cause");
endmodule : event_output_conditioner_assertions
bind event_output_conditioner event_output_conditioner_assertions #(.SP_W(SP_W)) i_event_output_conditioner_assertions (
    .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
    .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HSIZE_IN(HSIZE_IN), .HWDATA_IN(HWDATA_IN),
    .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .RAW_DECISION_IN(RAW_DECISION_IN), .READY_MODE_IN(READY_MODE_IN), .SETPOINT_VALUE_IN(SETPOINT_VALUE_IN),
    .ALARM_ACTIVE_IN(ALARM_ACTIVE_IN), .EVENT_OUT(EVENT_OUT), .STANDBY_ARMED_OUT(STANDBY_ARMED_OUT));
`default_nettype wire

// *** test/event_output_conditioner_test.sv ***
// self-checking testbench for the event output conditioner
`timescale 1ns/1ps
`default_nettype none
module event_output_conditioner_test;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic raw = 1'b0;
    logic ready = 1'b0;
    logic [15:0] sp = 16'h0100;
    logic alarm = 1'b0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic event_on;
    logic armed;
    int fail_count = 0;
    int n_compared = 0;
    always #20 clk = ~clk;
    event_output_conditioner i_event_output_conditioner (
        .SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .RAW_DECISION_IN(raw), .READY_MODE_IN(ready),
        .SETPOINT_VALUE_IN(sp), .ALARM_ACTIVE_IN(alarm), .EVENT_OUT(event_on), .STANDBY_ARMED_OUT(armed));
    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // hready sampled before the edge so the check never races the slave
    task automatic wait_rdy(output logic [31:0] rd);
        logic rdy;
        rdy = 1'b0;
        while (!rdy) begin
            @(negedge clk);
            rdy = hready;
            rd = hrdata;
            @(posedge clk);
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, adr};
        htrans <= event_cond_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy(rd);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask : bus
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, adr, d, rd);
    endtask : wr
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        bus(1'b0, adr, 32'h0, rd);
        chk(what, exp, rd);
    endtask : rd_chk
    // levels held two edges so a pending arm has landed before the look
    task automatic ev(input logic r, input logic y, input logic a, input logic [15:0] s, input logic exp);
        @(posedge clk);
        raw <= r;
        ready <= y;
        alarm <= a;
        sp <= s;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("event", {31'h0, exp}, {31'h0, event_on});
    endtask : ev
    function automatic logic combine(input int code, input logic e, input logic a);
        case (code)
            1: return e | a;
            2: return e & a;
            3: return e | !a;
            4: return e & !a;
            default: return e;
        endcase
    endfunction : combine
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd_chk(event_cond_pkg::OFS_CFG2, 32'h0, "cfg2 reset");
        rd_chk(event_cond_pkg::OFS_CFG3, 32'h0, "cfg3 reset");
        rd_chk(event_cond_pkg::OFS_OPTYPE, 32'h0, "optype reset");
        wr(event_cond_pkg::OFS_CFG3, 32'hFFFF_0004);
        rd_chk(event_cond_pkg::OFS_CFG3, 32'h0000_0004, "cfg3 width");
        wr(8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'h0, "unmapped");
        $display("test regs done");
    endtask : t_regs
    task automatic t_optype;
        wr(event_cond_pkg::OFS_CFG3, 32'h3);
        ev(1'b1, 1'b0, 1'b0, 16'h0100, 1'b0);
        ev(1'b0, 1'b0, 1'b0, 16'h0100, 1'b0);
        wr(event_cond_pkg::OFS_OPTYPE, 32'h1);
        ev(1'b0, 1'b0, 1'b0, 16'h0100, 1'b1);
        $display("test optype done");
    endtask : t_optype
    task automatic t_polarity;
        wr(event_cond_pkg::OFS_CFG3, 32'h0);
        ev(1'b1, 1'b0, 1'b0, 16'h0100, 1'b1);
        wr(event_cond_pkg::OFS_CFG2, 32'h1);
        ev(1'b0, 1'b0, 1'b0, 16'h0100, 1'b1);
        ev(1'b1, 1'b0, 1'b0, 16'h0100, 1'b0);
        wr(event_cond_pkg::OFS_CFG2, 32'h0);
        $display("test polarity done");
    endtask : t_polarity
    task automatic t_alarm;
        for (int c = 0; c < 5; c++) begin
            wr(event_cond_pkg::OFS_CFG3, c);
            for (int k = 0; k < 4; k++) begin
                ev(k[1], 1'b0, k[0], 16'h0100, combine(c, k[1], k[0]));
            end
        end
        wr(event_cond_pkg::OFS_CFG3, 32'h0);
        $display("test alarm done");
    endtask : t_alarm
    // every suppression and ready choice, then leaving ready for run
    task automatic t_ready;
        for (int s = 0; s < 3; s++) begin
            for (int d = 0; d < 2; d++) begin
                wr(event_cond_pkg::OFS_CFG2, {20'h0, d[3:0], s[3:0], 4'h0});
                ev(1'b1, 1'b1, 1'b0, 16'h0100, s == 0 && d == 0);
                // the very first edge after leaving ready must already be held
                @(posedge clk);
                ready <= 1'b0;
                @(posedge clk);
                @(negedge clk);
                chk("run entry", {31'h0, (s == 0)}, {31'h0, event_on});
                ev(1'b1, 1'b0, 1'b0, 16'h0100, s == 0);
                chk("armed", 32'h1, {31'h0, armed});
                rd_chk(event_cond_pkg::OFS_STATUS, {28'h0, 1'b0, 1'b1, 1'b1, (s == 0)}, "status");
                ev(1'b0, 1'b0, 1'b0, 16'h0100, 1'b0);
                ev(1'b1, 1'b0, 1'b0, 16'h0100, 1'b1);
            end
        end
        $display("test ready done");
    endtask : t_ready
    task automatic t_setpoint;
        wr(event_cond_pkg::OFS_CFG2, 32'h20);
        ev(1'b1, 1'b0, 1'b0, 16'h0101, 1'b0);
        ev(1'b0, 1'b0, 1'b0, 16'h0101, 1'b0);
        ev(1'b1, 1'b0, 1'b0, 16'h0101, 1'b1);
        ev(1'b1, 1'b0, 1'b0, 16'h0101, 1'b1);
        wr(event_cond_pkg::OFS_CFG2, 32'h10);
        ev(1'b1, 1'b0, 1'b0, 16'h0202, 1'b1);
        $display("test setpoint done");
    endtask : t_setpoint
    // reset pulsed mid-run with the raw decision already on
    task automatic t_power;
        @(posedge clk);
        arst_n <= 1'b0;
        raw <= 1'b1;
        ready <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        wr(event_cond_pkg::OFS_OPTYPE, 32'h1);
        wr(event_cond_pkg::OFS_CFG2, 32'h10);
        ev(1'b1, 1'b0, 1'b0, 16'h0202, 1'b0);
        chk("armed", 32'h1, {31'h0, armed});
        ev(1'b0, 1'b0, 1'b0, 16'h0202, 1'b0);
        ev(1'b1, 1'b0, 1'b0, 16'h0202, 1'b1);
        $display("test power done");
    endtask : t_power
    // ----------------------------------------------------------------
    // verdict, sequence and watchdog
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_optype();
        t_polarity();
        t_alarm();
        t_ready();
        t_setpoint();
        t_power();
        test_done();
    end
    // about 300 cycles expected, so 8000 leaves ample margin
    initial begin
        #(40 * 8000);
        fail_count++;
        $display("unexpected watchdog: expected finish seen hang");
        test_done();
    end
endmodule : event_output_conditioner_test
`default_nettype wire
